// >>> clock_power_reset_control_test.sv
// Self-checking bench for the clock, power and reset control
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  errors++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module clock_power_reset_control_test;
  typedef struct packed {
    logic [7:0] wdata;
    logic [7:0] rback;
    logic [31:0] ticks;
  } cprc_row_t;
  logic clk, rst, ce, reset_pin_n, sfr_hit, irq_pending, irq_enabled_any;
  logic sys_clk_en, cpu_clk_en, adc_clk_en, chip_reset, por_busy;
  logic serial_baud_double, ram_we, irq_cmd, en_cmd, seen;
  logic [7:0] sfr_rdata, ram_addr, ram_wdata, ram_rdata, rv;
  logic [31:0] sys_ticks, cpu_ticks, ns, nc;
  cprc_pkg::cprc_sfr_req_t sfr_req;
  cprc_pkg::cprc_wake_t wake;
  int errors, checks_done;
  cprc_row_t rows [12] = '{'{8'h00, 8'h00, 32'h400}, '{8'h01, 8'h01, 32'h200},
    '{8'h02, 8'h02, 32'h100}, '{8'h03, 8'h03, 32'h80},
    '{8'h04, 8'h04, 32'h40}, '{8'h05, 8'h05, 32'h20}, '{8'h06, 8'h06, 32'h10},
    '{8'h07, 8'h07, 32'h8}, '{8'h08, 8'h08, 32'h4}, '{8'h09, 8'h09, 32'h2},
    '{8'h1a, 8'h1a, 32'h2}, '{8'h6f, 8'h0f, 32'h2}};
  cprc_top dut_u (.clk(clk), .rst(rst), .ce(ce), .reset_pin_n(reset_pin_n),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .irq_pending(irq_pending), .irq_enabled_any(irq_enabled_any),
    .wake(wake), .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en),
    .adc_clk_en(adc_clk_en), .chip_reset(chip_reset), .por_busy(por_busy),
    .serial_baud_double(serial_baud_double), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
  cprc_irq_model model_u (.clk(clk), .rst(rst), .irq_cmd(irq_cmd),
    .en_cmd(en_cmd), .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en),
    .irq_pending(irq_pending), .irq_enabled_any(irq_enabled_any),
    .sys_ticks(sys_ticks), .cpu_ticks(cpu_ticks));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // One register write, strobe held for one edge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req.wr = 1'b1;
    sfr_req.addr = a;
    sfr_req.wdata = d;
    @(negedge clk);
    sfr_req.wr = 1'b0;
  endtask : sfr_write
  // One register read, data registered one edge after the address
  task automatic sfr_read(input logic [7:0] a);
    @(negedge clk);
    sfr_req.rd = 1'b1;
    sfr_req.addr = a;
    @(negedge clk);
    rv = sfr_rdata;
    sfr_req.rd = 1'b0;
  endtask : sfr_read
  // Enable ticks over n edges
  task automatic count_ticks(input int n);
    @(negedge clk);
    ns = sys_ticks;
    nc = cpu_ticks;
    repeat (n) @(negedge clk);
    ns = sys_ticks - ns;
    nc = cpu_ticks - nc;
  endtask : count_ticks
  // Look for a reset pulse within eight edges
  task automatic wait_reset();
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (chip_reset === 1'b1) seen = 1'b1;
    end
  endtask : wait_reset
  task automatic ram_read(input logic [7:0] a);
    @(negedge clk);
    ram_addr = a;
    @(negedge clk);
    rv = ram_rdata;
  endtask : ram_read
  task automatic stop_test();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Watchdog against a hang
  initial begin
    #(60000 * 20);
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    {rst, ce, reset_pin_n, ram_we, irq_cmd, en_cmd} = 6'h38;
    {ram_addr, ram_wdata, rv} = 24'h0;
    sfr_req = '0;
    wake = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    // Power-on clear, then memory and registers all zero
    for (int i = 0; i < 300 && por_busy !== 1'b0; i++) @(negedge clk);
    `CHK("por_busy", 1'b0, por_busy)
    @(negedge clk);
    `CHK("chip_reset", 1'b0, chip_reset)
    for (int i = 0; i < 256; i++) begin
      ram_read(i[7:0]);
      `CHK("ram_clear", 8'h00, rv)
    end
    sfr_read(8'h87);
    `CHK("pwr_rst", 8'h00, rv)
    `CHK("pwr_hit", 1'b1, sfr_hit)
    sfr_read(8'h94);
    `CHK("div_rst", 8'h00, rv)
    `CHK("div_hit", 1'b1, sfr_hit)
    // Divider codes, readback and tick rate
    for (int i = 0; i < 12; i++) begin
      sfr_write(8'h94, rows[i].wdata);
      sfr_read(8'h94);
      `CHK("div_rback", rows[i].rback, rv)
      repeat (600) @(negedge clk);
      count_ticks(1024);
      `CHK("div_ticks", rows[i].ticks, ns)
      `CHK("adc_en", 1'b1, adc_clk_en)
    end
    // Full speed in interrupt unless kept
    sfr_write(8'h94, 8'h03);
    irq_cmd = 1'b1;
    repeat (20) @(negedge clk);
    count_ticks(64);
    `CHK("irq_full", 32'h40, ns)
    irq_cmd = 1'b0;
    repeat (20) @(negedge clk);
    count_ticks(64);
    `CHK("irq_back", 32'h8, ns)
    sfr_write(8'h94, 8'h13);
    irq_cmd = 1'b1;
    repeat (20) @(negedge clk);
    count_ticks(64);
    `CHK("irq_keep", 32'h8, ns)
    irq_cmd = 1'b0;
    // Power register layout and an unmapped place
    sfr_write(8'h87, 8'hfc);
    sfr_read(8'h87);
    `CHK("pwr_rback", 8'hfc, rv)
    `CHK("baud_dbl", 1'b1, serial_baud_double)
    sfr_read(8'h88);
    `CHK("unmapped", 8'h00, rv)
    `CHK("unmapped_hit", 1'b0, sfr_hit)
    // Idle stops the core only; an enabled interrupt resumes it
    sfr_write(8'h94, 8'h00);
    sfr_write(8'h87, 8'h01);
    count_ticks(16);
    `CHK("idle_cpu", 32'h0, nc)
    `CHK("idle_sys", 32'h10, ns)
    sfr_read(8'h87);
    `CHK("idle_rd0", 8'h00, rv)
    en_cmd = 1'b1;
    repeat (3) @(negedge clk);
    count_ticks(16);
    `CHK("idle_wake", 32'h10, nc)
    en_cmd = 1'b0;
    // Stop ignores internal interrupts, each wake input ends it
    for (int k = 0; k < 4; k++) begin
      sfr_write(8'h87, 8'h02);
      en_cmd = 1'b1;
      count_ticks(16);
      `CHK("stop_sys", 32'h0, ns)
      en_cmd = 1'b0;
      wake = cprc_pkg::cprc_wake_t'(4'h1 << k);
      repeat (3) @(negedge clk);
      wake = '0;
      count_ticks(16);
      `CHK("stop_wake", 32'h10, ns)
    end
    // Software reset keeps the large memory contents
    ram_we = 1'b1;
    ram_addr = 8'h5a;
    ram_wdata = 8'ha5;
    @(negedge clk);
    ram_we = 1'b0;
    sfr_write(8'h94, 8'h83);
    wait_reset();
    `CHK("soft_rst", 1'b1, seen)
    sfr_read(8'h94);
    `CHK("soft_rd", 8'h00, rv)
    ram_read(8'h5a);
    `CHK("ram_keep", 8'ha5, rv)
    // Reset pin restores the power register
    sfr_write(8'h87, 8'h84);
    reset_pin_n = 1'b0;
    wait_reset();
    reset_pin_n = 1'b1;
    `CHK("pin_rst", 1'b1, seen)
    repeat (8) @(negedge clk);
    sfr_read(8'h87);
    `CHK("pin_pwr", 8'h00, rv)
    // Low clock enable freezes register writes
    ce = 1'b0;
    `CHK("adc_hold", 1'b0, adc_clk_en)
    sfr_write(8'h94, 8'h05);
    ce = 1'b1;
    sfr_read(8'h94);
    `CHK("ce_hold", 8'h00, rv)
    stop_test();
  end
endmodule : clock_power_reset_control_test

// >>> cprc_irq_model.sv
// Behavioural model of the interrupt logic and core beside the block
`timescale 1ns/1ps
module cprc_irq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic irq_cmd,
  input wire logic en_cmd,
  // Clock enables from the block
  input wire logic sys_clk_en,
  input wire logic cpu_clk_en,
  // Interrupt status to the block
  output logic irq_pending,
  output logic irq_enabled_any,
  // Enable ticks seen by the core
  output logic [31:0] sys_ticks,
  output logic [31:0] cpu_ticks
);
  // Interrupt lines follow the bench commands as levels
  assign irq_pending = irq_cmd;
  assign irq_enabled_any = en_cmd;
  // Count every edge on which the core or peripherals are enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_ticks <= 32'h0;
      cpu_ticks <= 32'h0;
    end else begin
      sys_ticks <= sys_ticks + {31'h0, sys_clk_en};
      cpu_ticks <= cpu_ticks + {31'h0, cpu_clk_en};
    end
  end
endmodule : cprc_irq_model

// >>> cprc_pkg.sv
// Package of constants and types for the clock, power and reset control
package cprc_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_CLOCK_DIVIDE_CONTROL = 8'h94;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SOFT_RESET_BIT = 7;
  localparam int IRQ_SPEED_KEEP_BIT = 4;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 3;
  localparam int BAUD_DOUBLE_BIT = 7;
  localparam int FLAG_ONE_BIT = 3;
  localparam int FLAG_ZERO_BIT = 2;
  localparam int STOP_BIT = 1;
  localparam int IDLE_BIT = 0;
  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [3:0] DIV_RESET = 4'h0;
  localparam logic [3:0] DIV_MAX_CODE = 4'h9;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam int RAM_DEPTH = 256;
  localparam logic [7:0] RAM_CLEAR = 8'h00;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cprc_sfr_req_t;
  typedef struct packed {
    logic ext_int_zero;
    logic ext_int_one;
    logic serial_rx;
    logic i2c_event;
  } cprc_wake_t;
  typedef enum logic [1:0] {CPRC_RUN, CPRC_IDLE, CPRC_STOP} cprc_mode_t;
endpackage : cprc_pkg

// >>> cprc_top.sv
// Clock divider, power modes, resets and on-chip data memory clearing
`timescale 1ns/1ps
module cprc_top (
  // Clock, enable and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reset_pin_n,
  // Special-function register access
  input wire cprc_pkg::cprc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Interrupt status from the interrupt logic, and wake inputs
  input wire logic irq_pending,
  input wire logic irq_enabled_any,
  input wire cprc_pkg::cprc_wake_t wake,
  // Clock enables to clients
  output logic sys_clk_en,
  output logic cpu_clk_en,
  output logic adc_clk_en,
  // Reset outputs
  output logic chip_reset,
  output logic por_busy,
  // Control bits to other blocks
  output logic serial_baud_double,
  // Internal 256-byte data memory port
  input wire logic ram_we,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  // ****************************************
  // Reset pin synchroniser
  // ****************************************
  logic [2:0] pin_sync_r;
  logic pin_level_r;
  logic [2:0] pin_sync_nxt;
  logic pin_level_nxt;
  // Three stages; level changes once last two agree
  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], reset_pin_n};
    pin_level_nxt = pin_level_r;
    if (pin_sync_r[2] == pin_sync_r[1]) begin
      pin_level_nxt = pin_sync_r[2];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_r <= 3'h7;
      pin_level_r <= 1'b1;
    end else if (ce) begin
      pin_sync_r <= pin_sync_nxt;
      pin_level_r <= pin_level_nxt;
    end
  end
  // ****************************************
  // Registers and mode
  // ****************************************
  logic [3:0] div_sel_r;
  logic irq_speed_keep_r;
  logic [7:0] pwr_ctl_r;
  logic soft_rst_r;
  cprc_pkg::cprc_mode_t mode_r;
  logic [3:0] div_sel_nxt;
  logic irq_speed_keep_nxt;
  logic [7:0] pwr_ctl_nxt;
  logic soft_rst_nxt;
  cprc_pkg::cprc_mode_t mode_nxt;
  logic wr_div;
  logic wr_pwr;
  logic wake_any;
  logic warm_reset;
  assign wr_div = sfr_req.wr &&
    (sfr_req.addr == cprc_pkg::ADDR_CLOCK_DIVIDE_CONTROL);
  assign wr_pwr = sfr_req.wr &&
    (sfr_req.addr == cprc_pkg::ADDR_POWER_MODE_CONTROL);
  assign wake_any = |wake;
  // Software reset lasts one cycle; pin reset lasts while the filtered pin level is low
  assign warm_reset = soft_rst_r || !pin_level_r;
  // Register writes and power mode sequencing
  always_comb begin
    div_sel_nxt = div_sel_r;
    irq_speed_keep_nxt = irq_speed_keep_r;
    pwr_ctl_nxt = pwr_ctl_r;
    soft_rst_nxt = 1'b0;
    mode_nxt = mode_r;
    if (wr_div) begin
      // Bits 6 and 5 are not stored
      div_sel_nxt = sfr_req.wdata[cprc_pkg::DIV_MSB:cprc_pkg::DIV_LSB];
      irq_speed_keep_nxt = sfr_req.wdata[cprc_pkg::IRQ_SPEED_KEEP_BIT];
      soft_rst_nxt = sfr_req.wdata[cprc_pkg::SOFT_RESET_BIT];
    end
    if (wr_pwr) begin
      // Flags are plain storage; stop/idle start modes
      pwr_ctl_nxt = sfr_req.wdata;
    end
    case (mode_r)
      cprc_pkg::CPRC_RUN: begin
        if (wr_pwr && sfr_req.wdata[cprc_pkg::STOP_BIT]) begin
          mode_nxt = cprc_pkg::CPRC_STOP;
        end else if (wr_pwr && sfr_req.wdata[cprc_pkg::IDLE_BIT]) begin
          mode_nxt = cprc_pkg::CPRC_IDLE;
        end
      end
      cprc_pkg::CPRC_IDLE: begin
        if (irq_enabled_any) begin
          mode_nxt = cprc_pkg::CPRC_RUN;
        end
      end
      cprc_pkg::CPRC_STOP: begin
        if (wake_any) begin
          mode_nxt = cprc_pkg::CPRC_RUN;
        end
      end
      default: mode_nxt = cprc_pkg::CPRC_RUN;
    endcase
    if (warm_reset) begin
      // Warm reset restores defaults, leaves memories
      div_sel_nxt = cprc_pkg::DIV_RESET;
      irq_speed_keep_nxt = 1'b0;
      pwr_ctl_nxt = cprc_pkg::POWER_RESET;
      mode_nxt = cprc_pkg::CPRC_RUN;
    end
  end
  // Stop freezes nothing here so wake sources still work
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_sel_r <= cprc_pkg::DIV_RESET;
      irq_speed_keep_r <= 1'b0;
      pwr_ctl_r <= cprc_pkg::POWER_RESET;
      soft_rst_r <= 1'b0;
      mode_r <= cprc_pkg::CPRC_RUN;
    end else if (ce) begin
      div_sel_r <= div_sel_nxt;
      irq_speed_keep_r <= irq_speed_keep_nxt;
      pwr_ctl_r <= pwr_ctl_nxt;
      soft_rst_r <= soft_rst_nxt;
      mode_r <= mode_nxt;
    end
  end
  // ****************************************
  // Clock divider
  // ****************************************
  logic [8:0] div_cnt_r;
  logic [8:0] div_cnt_nxt;
  logic [3:0] eff_code;
  logic [8:0] div_mask;
  logic tick;
  // Codes above 9 clamp to /512; interrupts may force /1
  always_comb begin
    eff_code = (div_sel_r > cprc_pkg::DIV_MAX_CODE) ?
      cprc_pkg::DIV_MAX_CODE : div_sel_r;
    if (irq_pending && !irq_speed_keep_r) begin
      eff_code = 4'h0;
    end
    div_mask = 9'((10'h1 << eff_code) - 10'h1);
  end
  // Counter runs free across code changes: tick when the masked count is all ones
  assign tick = ((div_cnt_r & div_mask) == div_mask);
  always_comb begin
    div_cnt_nxt = div_cnt_r + 9'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 9'h000;
    end else if (ce) begin
      div_cnt_r <= div_cnt_nxt;
    end
  end
  // Clock enables; stop gates system and processor, idle only the processor, adc_clk_en follows ce
  assign sys_clk_en = tick && (mode_r != cprc_pkg::CPRC_STOP);
  assign cpu_clk_en = sys_clk_en && (mode_r == cprc_pkg::CPRC_RUN);
  assign adc_clk_en = ce;
  // ****************************************
  // Power-on memory clearing and reset outputs
  // ****************************************
  logic [7:0] ram [cprc_pkg::RAM_DEPTH];
  logic [8:0] clr_cnt_r;
  logic [8:0] clr_cnt_nxt;
  logic [7:0] ram_rdata_r;
  logic chip_reset_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  assign por_busy = !clr_cnt_r[8];
  // Walk every address once after power-on
  always_comb begin
    clr_cnt_nxt = clr_cnt_r;
    if (por_busy) begin
      clr_cnt_nxt = clr_cnt_r + 9'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clr_cnt_r <= 9'h000;
      chip_reset_r <= 1'b1;
    end else if (ce) begin
      clr_cnt_r <= clr_cnt_nxt;
      chip_reset_r <= por_busy || warm_reset;
    end
  end
  // Memory has no reset; cleared only by power-on walk
  always_ff @(posedge clk) begin
    if (ce) begin
      if (por_busy) begin
        ram[clr_cnt_r[7:0]] <= cprc_pkg::RAM_CLEAR;
      end else if (ram_we) begin
        ram[ram_addr] <= ram_wdata;
      end
      ram_rdata_r <= ram[ram_addr];
    end
  end
  assign ram_rdata = ram_rdata_r;
  assign chip_reset = chip_reset_r;
  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdata_nxt = 8'h00;
    if (sfr_req.addr == cprc_pkg::ADDR_CLOCK_DIVIDE_CONTROL) begin
      rdata_nxt = {3'h0, irq_speed_keep_r, div_sel_r};
    end else if (sfr_req.addr == cprc_pkg::ADDR_POWER_MODE_CONTROL) begin
      rdata_nxt = {pwr_ctl_r[7:2], 2'h0};
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign sfr_rdata = rdata_r;
  assign sfr_hit = (sfr_req.addr == cprc_pkg::ADDR_CLOCK_DIVIDE_CONTROL) ||
    (sfr_req.addr == cprc_pkg::ADDR_POWER_MODE_CONTROL);
  assign serial_baud_double = pwr_ctl_r[cprc_pkg::BAUD_DOUBLE_BIT];
  // ****************************************
  // Assertions
  // ****************************************
  sequence s_div_write;
    ce && wr_div && !warm_reset;
  endsequence
  a_reads_zero_bits: assert property (@(posedge clk) disable iff (rst)
    (rdata_r[1:0] == 2'h0) || !$past(ce) || $past(sfr_req.addr) !=
    cprc_pkg::ADDR_POWER_MODE_CONTROL) else $error("stop/idle read");
  a_soft_reset_fires: assert property (@(posedge clk) disable iff (rst)
    s_div_write ##0 sfr_req.wdata[7] |-> ##2 chip_reset)
    else $error("soft reset lost");
  a_irq_full_speed: assert property (@(posedge clk) disable iff (rst)
    ce && irq_pending && !irq_speed_keep_r && mode_r != cprc_pkg::CPRC_STOP
    |-> sys_clk_en) else $error("not full speed");
  a_stop_no_clock: assert property (@(posedge clk) disable iff (rst)
    mode_r == cprc_pkg::CPRC_STOP |-> !sys_clk_en && !cpu_clk_en)
    else $error("clock in stop");
  a_idle_cpu_off: assert property (@(posedge clk) disable iff (rst)
    mode_r == cprc_pkg::CPRC_IDLE |-> !cpu_clk_en)
    else $error("cpu clock in idle");
  a_idle_wakes: assert property (@(posedge clk) disable iff (rst)
    ce && mode_r == cprc_pkg::CPRC_IDLE && irq_enabled_any
    |=> mode_r == cprc_pkg::CPRC_RUN) else $error("idle not left");
  a_stop_wakes: assert property (@(posedge clk) disable iff (rst)
    ce && mode_r == cprc_pkg::CPRC_STOP && !wake_any && !warm_reset
    |=> mode_r == cprc_pkg::CPRC_STOP) else $error("stop left");
  a_div_stored: assert property (@(posedge clk) disable iff (rst)
    s_div_write |=> div_sel_r == $past(sfr_req.wdata[3:0]))
    else $error("divisor not stored");
  a_slow_spacing: assert property (@(posedge clk) disable iff (rst)
    ce && tick && eff_code == 4'h1 ##1 eff_code == 4'h1 |-> !tick)
    else $error("short pulse");
endmodule : cprc_top
